// File: rtl/cacc_pkg.sv
// Function
// - counter mode bit 7 stops counter in idle
// - counter mode bit 6 enables module 4 watchdog
// - counter mode bits 2:1 select count source
// - sources: osc/12, osc/4 (osc/6, osc/2 in six-clock mode), timer0, external pin
// - counter mode bit 0 enables overflow interrupt
// - overflow flag set by hardware, software-only clear
// - control bit 6 runs the shared counter
// - control bits 4:0 module event flags
// - module mode register field layout
// - capture mode when either capture enable set
// - selected pin edge copies counter to compare
// - interrupt when event flag and enable set
// - comparator plus match flags counter equality
// - toggle plus match plus comparator inverts pin
// - pwm plus comparator selects pwm mode
// - pwm pin low below duty, else high
// - low byte wrap reloads duty from high
// - pwm modules share frequency, own duty
// - module 4 match under watchdog resets core
// - watchdog off leaves module 4 general purpose
// - five modules, each with its own pin
`default_nettype none
package cacc_pkg;
	// ===========================================================
	// geometry
	localparam int unsigned NUM_MODULES = 5;
	localparam int unsigned MOD4        = 4;
	typedef logic [7:0] cacc_byte_t;
	// ===========================================================
	// register map
	localparam logic [7:0] ADDR_CONTROL   = 8'hD8;
	localparam logic [7:0] ADDR_MODE      = 8'hD9;
	localparam logic [7:0] ADDR_MOD_MODE0 = 8'hDA;
	localparam logic [7:0] ADDR_CNT_LOW   = 8'hE9;
	localparam logic [7:0] ADDR_CMP_LOW0  = 8'hEA;
	localparam logic [7:0] ADDR_CNT_HIGH  = 8'hF9;
	localparam logic [7:0] ADDR_CMP_HIGH0 = 8'hFA;
	// ===========================================================
	// counter mode fields
	localparam int unsigned MODE_IDLE_STOP = 7;
	localparam int unsigned MODE_WDT_EN    = 6;
	localparam int unsigned MODE_SRC_HI    = 2;
	localparam int unsigned MODE_SRC_LO    = 1;
	localparam int unsigned MODE_OVF_IRQ   = 0;
	localparam logic [7:0]  MODE_WR_MASK   = 8'hC7;
	// counter control fields
	localparam int unsigned CTRL_OVF_FLAG  = 7;
	localparam int unsigned CTRL_RUN       = 6;
	localparam logic [7:0]  CTRL_WR_MASK   = 8'hDF;
	// module mode fields
	localparam int unsigned MM_CMP_EN      = 6;
	localparam int unsigned MM_CAP_RISE    = 5;
	localparam int unsigned MM_CAP_FALL    = 4;
	localparam int unsigned MM_MATCH_EN    = 3;
	localparam int unsigned MM_TOGGLE_EN   = 2;
	localparam int unsigned MM_PWM_EN      = 1;
	localparam int unsigned MM_IRQ_EN      = 0;
	localparam logic [7:0]  MM_WR_MASK     = 8'h7F;
	// ===========================================================
	// reset values and count sources
	localparam logic [7:0] RESET_BYTE  = 8'h00;
	localparam logic [1:0] SRC_OSC_SLOW = 2'h0;
	localparam logic [1:0] SRC_OSC_FAST = 2'h1;
	localparam logic [1:0] SRC_TIMER0   = 2'h2;
	localparam logic [1:0] SRC_EXT_PIN  = 2'h3;
	localparam logic [3:0] DIV_SLOW_12T = 4'hC;
	localparam logic [3:0] DIV_FAST_12T = 4'h4;
	localparam logic [3:0] DIV_SLOW_6T  = 4'h6;
	localparam logic [3:0] DIV_FAST_6T  = 4'h2;
endpackage
`default_nettype wire

// File: rtl/cacc_top.sv
// Strobed register access is this design's own decision.
`default_nettype none
module cacc_top
	import cacc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic        core_idle,
	input  wire logic        six_clock_mode,
	input  wire logic        timer0_overflow,
	input  wire logic        external_count_input,
	input  wire logic [4:0]  module_pin_in,
	output logic      [4:0]  module_pin_out,
	output logic      [4:0]  module_pin_oe,
	output logic             counter_array_irq,
	output logic             module4_watchdog_reset
);

	// ===========================================================
	// address decode
	function automatic logic [2:0] mod_index(input logic [7:0] a,
		input logic [7:0] base);
		logic [7:0] d;
		d = a - base;
		mod_index = d[2:0];
	endfunction

	function automatic logic in_bank(input logic [7:0] a,
		input logic [7:0] base);
		logic [7:0] d;
		d = a - base;
		in_bank = (d < 8'(NUM_MODULES));
	endfunction

	// ===========================================================
	// state
	logic [7:0]  mode_reg;
	logic        overflow_flag_reg;
	logic        run_reg;
	logic [4:0]  event_flag_reg;
	logic [15:0] counter_reg;
	logic        moved_reg;
	logic [3:0]  prescale_reg;
	logic [7:0]  mm_reg   [NUM_MODULES];
	logic [7:0]  cmp_lo_reg [NUM_MODULES];
	logic [7:0]  cmp_hi_reg [NUM_MODULES];
	logic [4:0]  pin_reg;
	logic [4:0]  pin_s1_reg;
	logic [4:0]  pin_s2_reg;
	logic [4:0]  pin_s3_reg;
	logic [2:0]  ext_sync_reg;
	logic        wdt_reset_reg;

	logic [4:0]  capture_evt;
	logic [4:0]  match_evt;
	logic        tick;
	logic        advance;
	logic        wrap;
	logic        low_wrap;
	logic [3:0]  div_value;

	// ===========================================================
	// pin and external count synchronisers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pin_s1_reg   <= 5'h00;
			pin_s2_reg   <= 5'h00;
			pin_s3_reg   <= 5'h00;
			ext_sync_reg <= 3'h0;
		end else begin
			pin_s1_reg   <= module_pin_in;
			pin_s2_reg   <= pin_s1_reg;
			pin_s3_reg   <= pin_s2_reg;
			ext_sync_reg <= {ext_sync_reg[1:0], external_count_input};
		end
	end

	// ===========================================================
	// count source selection
	always_comb begin
		if (mode_reg[MODE_SRC_HI:MODE_SRC_LO] == SRC_OSC_SLOW) begin
			div_value = six_clock_mode ? DIV_SLOW_6T : DIV_SLOW_12T;
		end else begin
			div_value = six_clock_mode ? DIV_FAST_6T : DIV_FAST_12T;
		end
	end

	// oscillator prescaler
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prescale_reg <= 4'h0;
		end else if (prescale_reg >= div_value - 4'h1) begin
			prescale_reg <= 4'h0;
		end else begin
			prescale_reg <= prescale_reg + 4'h1;
		end
	end

	always_comb begin
		case (mode_reg[MODE_SRC_HI:MODE_SRC_LO])
			SRC_OSC_SLOW: tick = (prescale_reg == div_value - 4'h1);
			SRC_OSC_FAST: tick = (prescale_reg == div_value - 4'h1);
			SRC_TIMER0:   tick = timer0_overflow;
			SRC_EXT_PIN:  tick = ext_sync_reg[1] & ~ext_sync_reg[2];
			default:      tick = 1'b0;
		endcase
	end

	// run gating and idle stop
	assign advance = tick & run_reg
		& ~(core_idle & mode_reg[MODE_IDLE_STOP]);
	assign wrap     = advance & (counter_reg == 16'hFFFF);
	assign low_wrap = advance & (counter_reg[7:0] == 8'hFF);

	// ===========================================================
	// shared counter, writable from software
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			counter_reg <= 16'h0000;
			moved_reg   <= 1'b0;
		end else begin
			moved_reg <= advance;
			if (advance) begin
				counter_reg <= counter_reg + 16'h0001;
			end else if (reg_wr && reg_addr == ADDR_CNT_LOW) begin
				counter_reg[7:0] <= reg_wdata;
			end else if (reg_wr && reg_addr == ADDR_CNT_HIGH) begin
				counter_reg[15:8] <= reg_wdata;
			end
		end
	end

	// ===========================================================
	// counter mode register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode_reg <= RESET_BYTE;
		end else if (reg_wr && reg_addr == ADDR_MODE) begin
			mode_reg <= reg_wdata & MODE_WR_MASK;
		end
	end

	// control register: hardware set wins over software clear
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			overflow_flag_reg <= 1'b0;
			run_reg           <= 1'b0;
			event_flag_reg    <= 5'h00;
		end else begin
			if (reg_wr && reg_addr == ADDR_CONTROL) begin
				overflow_flag_reg <= reg_wdata[CTRL_OVF_FLAG] | wrap;
				run_reg           <= reg_wdata[CTRL_RUN];
				event_flag_reg    <= reg_wdata[4:0]
					| capture_evt | match_evt;
			end else begin
				overflow_flag_reg <= overflow_flag_reg | wrap;
				event_flag_reg    <= event_flag_reg
					| capture_evt | match_evt;
			end
		end
	end

	// ===========================================================
	// capture/compare modules
	genvar m;
	generate
		for (m = 0; m < NUM_MODULES; m++) begin : g_mod
			logic rise;
			logic fall;
			logic equal;
			logic pwm_mode;
			logic sel;

			assign sel   = (mod_index(reg_addr, ADDR_MOD_MODE0)
				== 3'(m));
			assign rise  = pin_s2_reg[m] & ~pin_s3_reg[m];
			assign fall  = ~pin_s2_reg[m] & pin_s3_reg[m];
			assign equal = moved_reg
				&& counter_reg == {cmp_hi_reg[m], cmp_lo_reg[m]};
			assign pwm_mode = mm_reg[m][MM_PWM_EN]
				& mm_reg[m][MM_CMP_EN];

			// edge capture in capture mode
			assign capture_evt[m] =
				(mm_reg[m][MM_CAP_RISE] & rise)
				| (mm_reg[m][MM_CAP_FALL] & fall);
			// compare match, software timer and toggle share it
			assign match_evt[m] = equal & mm_reg[m][MM_CMP_EN]
				& mm_reg[m][MM_MATCH_EN] & ~pwm_mode;

			// module mode register
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					mm_reg[m] <= RESET_BYTE;
				end else if (reg_wr && sel
					&& in_bank(reg_addr, ADDR_MOD_MODE0)) begin
					mm_reg[m] <= reg_wdata & MM_WR_MASK;
				end
			end

			// compare/capture registers; low byte is pwm duty
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					cmp_lo_reg[m] <= RESET_BYTE;
					cmp_hi_reg[m] <= RESET_BYTE;
				end else if (capture_evt[m]) begin
					cmp_lo_reg[m] <= counter_reg[7:0];
					cmp_hi_reg[m] <= counter_reg[15:8];
				end else begin
					if (pwm_mode && low_wrap) begin
						cmp_lo_reg[m] <= cmp_hi_reg[m];
					end else if (reg_wr && in_bank(reg_addr,
						ADDR_CMP_LOW0) && mod_index(reg_addr,
						ADDR_CMP_LOW0) == 3'(m)) begin
						cmp_lo_reg[m] <= reg_wdata;
					end
					if (reg_wr && in_bank(reg_addr, ADDR_CMP_HIGH0)
						&& mod_index(reg_addr, ADDR_CMP_HIGH0)
						== 3'(m)) begin
						cmp_hi_reg[m] <= reg_wdata;
					end
				end
			end

			// pin output: toggle on match or pwm level
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					pin_reg[m] <= 1'b0;
				end else if (pwm_mode) begin
					pin_reg[m] <= (counter_reg[7:0]
						>= cmp_lo_reg[m]);
				end else if (match_evt[m]
					&& mm_reg[m][MM_TOGGLE_EN]) begin
					pin_reg[m] <= ~pin_reg[m];
				end
			end

			assign module_pin_oe[m] = pwm_mode
				| (mm_reg[m][MM_TOGGLE_EN] & mm_reg[m][MM_CMP_EN]);
		end
	endgenerate

	assign module_pin_out = pin_reg;

	// ===========================================================
	// module 4 watchdog reset pulse
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wdt_reset_reg <= 1'b0;
		end else begin
			wdt_reset_reg <= mode_reg[MODE_WDT_EN]
				& match_evt[MOD4];
		end
	end

	assign module4_watchdog_reset = wdt_reset_reg;

	// interrupt request
	assign counter_array_irq =
		(overflow_flag_reg & mode_reg[MODE_OVF_IRQ])
		| (|(event_flag_reg & {mm_reg[4][MM_IRQ_EN],
			mm_reg[3][MM_IRQ_EN], mm_reg[2][MM_IRQ_EN],
			mm_reg[1][MM_IRQ_EN], mm_reg[0][MM_IRQ_EN]}));

	// ===========================================================
	// register read, data one cycle after strobe
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reg_rdata <= RESET_BYTE;
		end else if (reg_rd) begin
			if (reg_addr == ADDR_CONTROL) begin
				reg_rdata <= {overflow_flag_reg, run_reg, 1'b0,
					event_flag_reg};
			end else if (reg_addr == ADDR_MODE) begin
				reg_rdata <= mode_reg;
			end else if (reg_addr == ADDR_CNT_LOW) begin
				reg_rdata <= counter_reg[7:0];
			end else if (reg_addr == ADDR_CNT_HIGH) begin
				reg_rdata <= counter_reg[15:8];
			end else if (in_bank(reg_addr, ADDR_MOD_MODE0)) begin
				reg_rdata <= mm_reg[mod_index(reg_addr, ADDR_MOD_MODE0)];
			end else if (in_bank(reg_addr, ADDR_CMP_LOW0)) begin
				reg_rdata <= cmp_lo_reg[mod_index(reg_addr,
					ADDR_CMP_LOW0)];
			end else if (in_bank(reg_addr, ADDR_CMP_HIGH0)) begin
				reg_rdata <= cmp_hi_reg[mod_index(reg_addr,
					ADDR_CMP_HIGH0)];
			end else begin
				reg_rdata <= RESET_BYTE;                     // unmapped
			end
		end else begin
			reg_rdata <= RESET_BYTE;
		end
	end

endmodule
`default_nettype wire

// File: tb/cacc_pin_model.sv
`default_nettype none
module cacc_pin_model (
	input  wire logic [4:0] drive_level,
	input  wire logic       count_level,
	input  wire logic [4:0] module_pin_out,
	input  wire logic [4:0] module_pin_oe,
	output logic      [4:0] module_pin_in,
	output logic            external_count_input
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// pin resolution: five module pins, driven side wins
	assign module_pin_in = (module_pin_oe & module_pin_out)
		| (~module_pin_oe & drive_level);
	// external count pin follows the far side level
	assign external_count_input = count_level;
endmodule
`default_nettype wire

// File: tb/cacc_checker.sv
`default_nettype none
module cacc_checker
	import cacc_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [4:0] module_pin_out,
	input wire logic [4:0] module_pin_oe,
	input wire logic       counter_array_irq,
	input wire logic       module4_watchdog_reset
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mode_reg;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// shadow of the counter mode register
	always_ff @(posedge ref_clk) begin
		if (rst)
			mode_reg <= 8'h00;
		else if (reg_wr && reg_addr == ADDR_MODE)
			mode_reg <= reg_wdata & MODE_WR_MASK;
	end
	// ==========================================================
	// assertions
	AST_MODE_READ: assert property (reg_rd && reg_addr == ADDR_MODE
		|=> reg_rdata == mode_reg) else $error("mode readback wrong");
	AST_CTRL_RSVD: assert property (reg_rd && reg_addr == ADDR_CONTROL
		|=> !reg_rdata[5]) else $error("control bit 5 not zero");
	AST_MOD_RSVD: assert property (reg_rd && reg_addr >= ADDR_MOD_MODE0
		&& reg_addr <= ADDR_MOD_MODE0 + 8'h04 |=> !reg_rdata[7])
		else $error("module mode bit 7 not zero");
	AST_WDT_GATED: assert property (module4_watchdog_reset
		|-> $past(mode_reg[MODE_WDT_EN])) else $error("reset without enable");
	AST_WDT_PULSE: assert property ($rose(module4_watchdog_reset)
		|=> !module4_watchdog_reset) else $error("reset pulse too long");
	AST_OVF_IRQ: assert property (reg_rd && reg_addr == ADDR_CONTROL
		&& mode_reg[MODE_OVF_IRQ] ##1 reg_rdata[CTRL_OVF_FLAG]
		|-> counter_array_irq) else $error("overflow irq missing");
	AST_OE_STEADY: assert property ($changed(module_pin_oe)
		|-> $past(reg_wr)) else $error("pin enable moved alone");
	AST_IRQ_HOLD: assert property (counter_array_irq && !reg_wr
		|=> counter_array_irq) else $error("irq dropped alone");
	// ==========================================================
	// covers
	COV_WDT: cover property (module4_watchdog_reset);
	COV_IRQ: cover property ($rose(counter_array_irq));
	COV_PIN: cover property ($rose(module_pin_out[0]));
endmodule
bind cacc_top cacc_checker u_chk (.ref_clk(ref_clk), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .module_pin_out(module_pin_out),
	.module_pin_oe(module_pin_oe), .counter_array_irq(counter_array_irq),
	.module4_watchdog_reset(module4_watchdog_reset));
`default_nettype wire

// File: tb/test_counter_array_capture_compare.sv
`default_nettype none
module test_counter_array_capture_compare
	import cacc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic       ref_clk = 1'b0;
	logic       rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic       core_idle = 1'b0;
	logic       six_clk = 1'b0;
	logic       t0_ovf = 1'b0;
	logic       count_level = 1'b0;
	logic [4:0] drive_level = 5'h00;
	logic [7:0] reg_rdata, last_rd, exp_v;
	logic [4:0] pin_in, pin_out, pin_oe;
	logic       ext_in, irq, wdt_rst;
	int         wdt_cnt = 0;
	int         n_mismatch = 0;
	int         checks_done = 0;
	int         divs[4] = '{12, 4, 6, 2};
	cacc_top dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .core_idle(core_idle),
		.six_clock_mode(six_clk), .timer0_overflow(t0_ovf),
		.external_count_input(ext_in), .module_pin_in(pin_in),
		.module_pin_out(pin_out), .module_pin_oe(pin_oe),
		.counter_array_irq(irq), .module4_watchdog_reset(wdt_rst));
	cacc_pin_model pins (.drive_level(drive_level),
		.count_level(count_level), .module_pin_out(pin_out),
		.module_pin_oe(pin_oe), .module_pin_in(pin_in),
		.external_count_input(ext_in));
	// clock and reset pulse counter
	always #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (wdt_rst === 1'b1) wdt_cnt++;
	// ==========================================================
	// tasks
	task automatic chk(input logic [7:0] seen, exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, exp, input string what);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		last_rd = reg_rdata;
		chk(reg_rdata, exp, what);
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			t0_ovf <= 1'b1;
			@(posedge ref_clk);
			t0_ovf <= 1'b0;
		end
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic restart(input logic [7:0] mode, lo);
		wr(ADDR_CONTROL, 8'h00);
		wr(ADDR_CNT_HIGH, 8'h00);
		wr(ADDR_CNT_LOW, lo);
		wr(ADDR_MODE, mode);
		wr(ADDR_CONTROL, 8'h40);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========================================================
	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		summarize();
	end
	// ==========================================================
	// tests
	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		for (int a = 'h00; a <= 'hFE; a += 2) rc(8'(a), 8'h00, "reset");
		wr(ADDR_MODE, 8'hFF);
		rc(ADDR_MODE, 8'hC7, "mode");
		wr(ADDR_MOD_MODE0 + 8'h01, 8'hFF);
		rc(ADDR_MOD_MODE0 + 8'h01, 8'h7F, "module mode");
		wr(ADDR_MOD_MODE0 + 8'h01, 8'h00);
		wr(ADDR_CONTROL, 8'hBF);
		rc(ADDR_CONTROL, 8'h9F, "soft set");
		chk({7'h0, irq}, 8'h01, "irq");
		wr(ADDR_CONTROL, 8'h00);
		rc(ADDR_CONTROL, 8'h00, "soft clear");
		$display("test registers done");
		restart(8'h84, 8'h00);
		tick(3);
		core_idle <= 1'b1;
		tick(2);
		rc(ADDR_CNT_LOW, 8'h03, "idle stop");
		wr(ADDR_MODE, 8'h06);
		core_idle <= 1'b0;
		repeat (3) begin
			count_level <= 1'b1;
			repeat (4) @(posedge ref_clk);
			count_level <= 1'b0;
			repeat (4) @(posedge ref_clk);
		end
		rc(ADDR_CNT_LOW, 8'h06, "external");
		wr(ADDR_MODE, 8'h04);
		core_idle <= 1'b1;
		tick(2);
		core_idle <= 1'b0;
		rc(ADDR_CNT_LOW, 8'h08, "idle run");
		for (int s = 0; s < 4; s++) begin
			six_clk <= s[1];
			restart(8'(s[0] * 2), 8'h00);
			repeat (118) @(posedge ref_clk);
			wr(ADDR_CONTROL, 8'h00);
			exp_v = 8'(120 / divs[s]);
			rc(ADDR_CNT_LOW, exp_v, "div raw");
			chk((last_rd + 8'h01 - exp_v) <= 8'h02 ? exp_v : last_rd, exp_v,
				"divider");
		end
		six_clk <= 1'b0;
		$display("test count sources done");
		wr(ADDR_CNT_HIGH, 8'hFF);
		wr(ADDR_CNT_LOW, 8'hFF);
		wr(ADDR_MODE, 8'h05);
		wr(ADDR_CONTROL, 8'h40);
		tick(1);
		rc(ADDR_CONTROL, 8'hC0, "overflow");
		chk({7'h0, irq}, 8'h01, "overflow irq");
		rc(ADDR_CNT_HIGH, 8'h00, "wrap");
		wr(ADDR_MOD_MODE0, 8'h4D);
		wr(ADDR_CMP_LOW0, 8'h03);
		restart(8'h04, 8'h00);
		tick(3);
		rc(ADDR_CONTROL, 8'h41, "match");
		chk({7'h0, pin_out[0]}, 8'h01, "toggle");
		chk({7'h0, irq}, 8'h01, "match irq");
		wr(ADDR_MOD_MODE0 + 8'h01, 8'h20);
		wr(ADDR_MOD_MODE0 + 8'h02, 8'h10);
		drive_level <= 5'h06;
		repeat (5) @(posedge ref_clk);
		rc(ADDR_CONTROL, 8'h43, "rise");
		rc(ADDR_CMP_LOW0 + 8'h01, 8'h03, "capture");
		tick(1);
		drive_level <= 5'h00;
		repeat (5) @(posedge ref_clk);
		rc(ADDR_CONTROL, 8'h47, "fall");
		rc(ADDR_CMP_LOW0 + 8'h02, 8'h04, "capture");
		$display("test events done");
		wr(ADDR_MOD_MODE0 + 8'h03, 8'h42);
		wr(ADDR_CMP_LOW0 + 8'h03, 8'h80);
		wr(ADDR_CMP_HIGH0 + 8'h03, 8'h81);
		restart(8'h04, 8'h7E);
		tick(1);
		chk({7'h0, pin_out[3]}, 8'h00, "pwm low");
		chk({3'h0, pin_oe}, 8'h09, "pin enable");
		tick(1);
		chk({7'h0, pin_out[3]}, 8'h01, "pwm high");
		wr(ADDR_CNT_LOW, 8'hFE);
		tick(2);
		rc(ADDR_CMP_LOW0 + 8'h03, 8'h81, "reload");
		wr(ADDR_CNT_LOW, 8'h7F);
		tick(1);
		chk({7'h0, pin_out[3]}, 8'h00, "new duty");
		$display("test pwm done");
		wr(ADDR_MOD_MODE0 + 8'h04, 8'h48);
		wr(ADDR_CMP_LOW0 + 8'h04, 8'h02);
		restart(8'h44, 8'h00);
		tick(2);
		chk(8'(wdt_cnt), 8'h01, "watchdog");
		restart(8'h04, 8'h00);
		tick(2);
		chk(8'(wdt_cnt), 8'h01, "no watchdog");
		rc(ADDR_CONTROL, 8'h50, "module 4 flag");
		$display("test watchdog done");
		summarize();
	end
endmodule
`default_nettype wire
